// file: rtl/sdram_wr_pkg.sv
// Constants and types shared by the write path of the DRAM device model
package sdram_wr_pkg;
	// Data, mask and address widths (x16 organisation)
	localparam int DQ_W = 16;
	localparam int MASK_W = 2;
	localparam int ROW_W = 13;
	localparam int COL_W = 9;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int ADDR_W = 13;
	// Address bit that selects auto precharge or all banks
	localparam int AP_BIT = 10;
	// Command codes {chip select, row, column, write enable}
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// Burst length codes
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	// Burst lengths as element counts
	localparam logic [9:0] LEN_1 = 10'h001;
	localparam logic [9:0] LEN_2 = 10'h002;
	localparam logic [9:0] LEN_4 = 10'h004;
	localparam logic [9:0] LEN_8 = 10'h008;
	localparam logic [9:0] LEN_PAGE = 10'h200;
	// Last column of a page
	localparam logic [COL_W-1:0] COL_LAST = 9'h1ff;
	// Clock and write recovery timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int WR_RECOVERY_NS = 15;
	localparam int WR_REC_RAW =
		(WR_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// One whole clock plus time: never fewer than two edges
	localparam int WR_REC_INT = (WR_REC_RAW < 2) ? 2 : WR_REC_RAW;
	localparam int REC_W = 4;
	localparam logic [REC_W-1:0] WR_REC_CYC = REC_W'(WR_REC_INT);
	localparam logic [REC_W-1:0] REC_ONE = 4'h1;
	// Write request FIFO shape
	localparam int FIFO_DEPTH = 4;
	localparam int REQ_W = BANK_W + ROW_W + COL_W + DQ_W + MASK_W;
	// Power state, one-hot
	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_PRE = 3'b010,
		PWR_ACT = 3'b100
	} pwr_state_t;
endpackage

// file: rtl/write_fifo.sv
// Small FIFO holding write requests on their way to the array
`timescale 1ns/100ps
`default_nettype none
module write_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	// Storage words
	logic [WIDTH-1:0] mem [DEPTH];
	// Read and write pointers
	logic [PW-1:0] rd_ptr;
	logic [PW-1:0] wr_ptr;
	// Occupancy
	logic [PW:0] count;
	logic push;
	logic pop;

	// Honest full and empty
	assign in_ready = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Head word straight from the storage registers
	assign out_data = mem[rd_ptr];

	// Storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // write_fifo
`default_nettype wire

// file: rtl/sdram_write_precharge_powerdown.sv
// Write bursts, precharge and power-down of a four-bank DRAM device
`timescale 1ns/100ps
`default_nettype none
module sdram_write_precharge_powerdown
	import sdram_wr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [2:0] burst_len_code,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [MASK_W-1:0] dqm,
	output logic write_path_ready,
	output logic arr_valid,
	input wire logic arr_ready,
	output logic [BANK_W-1:0] arr_bank,
	output logic [ROW_W-1:0] arr_row,
	output logic [COL_W-1:0] arr_col,
	output logic [DQ_W-1:0] arr_data,
	output logic [MASK_W-1:0] arr_mask,
	output logic [NBANK-1:0] bank_open,
	output logic [NBANK-1:0] precharge_strobe,
	output logic power_down,
	output logic active_power_down
);
	// Burst length in elements for a code
	function automatic logic [9:0] burst_len(input logic [2:0] code);
		logic [9:0] len;
		len = LEN_1;
		unique case (code)
			BL_2: len = LEN_2;
			BL_4: len = LEN_4;
			BL_8: len = LEN_8;
			BL_PAGE: len = LEN_PAGE;
			default: len = LEN_1;
		endcase
		return len;
	endfunction

	// Column after col within the burst
	function automatic logic [COL_W-1:0] col_next(
		input logic [COL_W-1:0] col,
		input logic [COL_W-1:0] start,
		input logic [2:0] code);
		logic [COL_W-1:0] wrap;
		logic [COL_W-1:0] inc;
		wrap = COL_W'(burst_len(code) - 10'h001);
		inc = col + 1'b1;
		if (code == BL_PAGE)
			return (col == COL_LAST) ? start : inc;
		else
			return (col & ~wrap) | (inc & wrap);
	endfunction

	// Power state
	pwr_state_t pwr;
	// Clock enable seen at the previous edge
	logic cke_prev;
	// Open row per bank
	logic [ROW_W-1:0] row [NBANK];
	// Burst in progress and its context
	logic burst_on;
	logic [BANK_W-1:0] bst_bank;
	logic [COL_W-1:0] bst_col;
	logic [COL_W-1:0] bst_start;
	logic [2:0] bst_code;
	logic [9:0] bst_left;
	logic bst_ap;
	// Write recovery countdown per bank
	logic [REC_W-1:0] rec_cnt [NBANK];
	// Decode
	logic [3:0] cmd;
	logic awake;
	logic nop_inh;
	logic is_write;
	logic is_read;
	logic is_pre;
	logic is_act;
	logic is_bst;
	logic [BANK_W-1:0] bank_in;
	logic pre_hits;
	logic burst_cont;
	logic burst_last;
	logic wr_single;
	logic [NBANK-1:0] ap_start;
	logic [NBANK-1:0] ap_done;
	logic rec_busy;
	// FIFO feed
	logic push_valid;
	logic [BANK_W-1:0] push_bank;
	logic [COL_W-1:0] push_col;
	logic [REQ_W-1:0] push_data;
	logic [REQ_W-1:0] head;

	// Strobes form the command word
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	// Inputs only count when running with clock enable high
	assign awake = (pwr == PWR_RUN) && cke;
	assign nop_inh = cs_n || (cmd == CMD_NOP);
	assign is_write = awake && (cmd == CMD_WRITE);
	assign is_read = awake && (cmd == CMD_READ);
	assign is_pre = awake && (cmd == CMD_PRE);
	assign is_act = awake && (cmd == CMD_ACT);
	assign is_bst = awake && (cmd == CMD_BST);
	assign bank_in = {bank_select_high, bank_select_low};
	// Precharge that closes the bursting bank ends its data
	assign pre_hits = is_pre && (addr[AP_BIT] || bank_in == bst_bank);
	// Burst data keeps flowing unless a command ends it
	assign burst_cont = burst_on && awake && !is_write && !is_read
		&& !is_bst && !pre_hits;
	// Element taken now is the last of a fixed burst
	assign burst_last = burst_cont && (bst_code != BL_PAGE)
		&& (bst_left == 10'h001);
	// Single-element write finishes on its own edge
	assign wr_single = is_write && (burst_len(burst_len_code) == LEN_1);

	// Auto precharge starts when its burst ends or is cut by a write, read or burst stop
	always_comb
	begin
		ap_start = '0;
		if (wr_single && addr[AP_BIT])
			ap_start[bank_in] = 1'b1;
		if (bst_ap && (burst_last
			|| (burst_on && (is_write || is_read || is_bst))))
			ap_start[bst_bank] = 1'b1;
	end

	// Recovery countdown expiry per bank
	always_comb
	begin
		ap_done = '0;
		rec_busy = 1'b0;
		for (int b = 0; b < NBANK; b++)
		begin
			if (rec_cnt[b] == REC_ONE)
				ap_done[b] = 1'b1;
			if (rec_cnt[b] != '0)
				rec_busy = 1'b1;
		end
	end

	// Pick the element offered to the array this edge
	always_comb
	begin
		push_valid = is_write || burst_cont;
		push_bank = is_write ? bank_in : bst_bank;
		push_col = is_write ? addr[COL_W-1:0] : bst_col;
		push_data = {push_bank, row[push_bank], push_col, dq_in, dqm};
	end

	// Write requests wait here for the array
	write_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push_valid),
		.in_ready(write_path_ready),
		.in_data(push_data),
		.out_valid(arr_valid),
		.out_ready(arr_ready),
		.out_data(head)
	);

	// Split the head word toward the array
	assign arr_mask = head[MASK_W-1:0];
	assign arr_data = head[MASK_W +: DQ_W];
	assign arr_col = head[MASK_W+DQ_W +: COL_W];
	assign arr_row = head[MASK_W+DQ_W+COL_W +: ROW_W];
	assign arr_bank = head[REQ_W-1 -: BANK_W];
	// Device never drives data during writes
	assign dq_out = '0;
	assign dq_oe = 1'b0;

	// Burst tracking
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			burst_on <= 1'b0;
			bst_bank <= '0;
			bst_col <= '0;
			bst_start <= '0;
			bst_code <= BL_1;
			bst_left <= '0;
			bst_ap <= 1'b0;
		end
		else if (is_write)
		begin
			// New write replaces any running burst
			bst_bank <= bank_in;
			bst_start <= addr[COL_W-1:0];
			bst_col <= col_next(addr[COL_W-1:0], addr[COL_W-1:0],
				burst_len_code);
			bst_code <= burst_len_code;
			bst_left <= burst_len(burst_len_code) - 10'h001;
			bst_ap <= addr[AP_BIT];
			burst_on <= !wr_single;
		end
		else if (burst_cont)
		begin
			// Step to the next column
			bst_col <= col_next(bst_col, bst_start, bst_code);
			bst_left <= bst_left - 10'h001;
			if (burst_last)
				burst_on <= 1'b0;
		end
		else if (burst_on && awake)
		begin
			// Read, burst stop or precharge ends the burst
			burst_on <= 1'b0;
			bst_ap <= 1'b0;
		end
	end

	// Write recovery countdown before auto precharge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int b = 0; b < NBANK; b++)
				rec_cnt[b] <= '0;
		end
		else
		begin
			for (int b = 0; b < NBANK; b++)
			begin
				if (ap_start[b])
					rec_cnt[b] <= WR_REC_CYC;
				else if (rec_cnt[b] != '0)
					rec_cnt[b] <= rec_cnt[b] - 1'b1;
			end
		end
	end

	// Row activation bookkeeping
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int b = 0; b < NBANK; b++)
				row[b] <= '0;
		end
		else if (is_act)
			row[bank_in] <= addr[ROW_W-1:0];
	end

	// Open and closed banks
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bank_open <= '0;
			precharge_strobe <= '0;
		end
		else
		begin
			precharge_strobe <= ap_done;
			if (is_pre && addr[AP_BIT])
			begin
				// All banks close, bank select ignored
				bank_open <= '0;
				precharge_strobe <= '1;
			end
			else if (is_pre)
			begin
				// Recovery expiry on other banks still closes them
				bank_open <= bank_open & ~ap_done;
				// One named bank closes
				bank_open[bank_in] <= 1'b0;
				precharge_strobe[bank_in] <= 1'b1;
			end
			else
			begin
				// Activation opens, recovery expiry closes
				bank_open <= bank_open & ~ap_done;
				if (is_act)
					bank_open[bank_in] <= 1'b1;
			end
		end
	end

	// Clock enable history
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cke_prev <= 1'b1;
		else
			cke_prev <= cke;
	end

	// Power-down entry and exit
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pwr <= PWR_RUN;
		else
		begin
			unique case (pwr)
				PWR_RUN:
				begin
					// Enter only with no burst or write recovery in flight; queued array writes may remain
					if (cke_prev && !cke && nop_inh && !burst_on
						&& !rec_busy)
						pwr <= (bank_open == '0) ? PWR_PRE : PWR_ACT;
				end
				PWR_PRE, PWR_ACT:
				begin
					// Exit edge leaves the next edge free for commands
					if (cke && nop_inh)
						pwr <= PWR_RUN;
				end
				default:
					pwr <= PWR_RUN;
			endcase
		end
	end

	// Power state flags
	assign power_down = (pwr != PWR_RUN);
	assign active_power_down = (pwr == PWR_ACT);
endmodule // sdram_write_precharge_powerdown
`default_nettype wire

// file: verification/sdram_wpp_sva.sv
// Port assertions for the DRAM write path block
`timescale 1ns/100ps
`default_nettype none
module sdram_wpp_sva
	import sdram_wr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [2:0] burst_len_code,
	input wire logic dq_oe,
	input wire logic write_path_ready,
	input wire logic arr_valid,
	input wire logic [NBANK-1:0] bank_open,
	input wire logic [NBANK-1:0] precharge_strobe,
	input wire logic power_down,
	input wire logic active_power_down
);
	logic [3:0] cmd; // Strobes as one code
	logic [1:0] bk; // Addressed bank
	logic go; // Command is taken
	logic nop; // No-op or inhibit
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign bk = {bank_select_high, bank_select_low};
	assign go = cke && !power_down;
	assign nop = cs_n || cmd == CMD_NOP;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Exit edge, then a command on the next edge
	sequence s_wake;
		power_down && cke && nop;
	endsequence
	sequence s_open;
		cke && cmd == CMD_ACT;
	endsequence
	property p_push;
		go && cmd == CMD_WRITE && write_path_ready |=> arr_valid;
	endproperty
	a_push: assert property (p_push) else $error("write lost");
	property p_quiet;
		!dq_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("data driven");
	property p_act;
		go && cmd == CMD_ACT |=> bank_open[$past(bk)];
	endproperty
	a_act: assert property (p_act) else $error("row not open");
	property p_pre1;
		go && cmd == CMD_PRE && !addr[AP_BIT] |=> !bank_open[$past(bk)];
	endproperty
	a_pre1: assert property (p_pre1) else $error("bank open");
	property p_strobe;
		go && cmd == CMD_PRE && !addr[AP_BIT]
		|=> precharge_strobe[$past(bk)];
	endproperty
	a_strobe: assert property (p_strobe) else $error("no strobe");
	property p_preall;
		go && cmd == CMD_PRE && addr[AP_BIT] |=> bank_open == 4'h0;
	endproperty
	a_preall: assert property (p_preall) else $error("banks open");
	property p_ap;
		go && cmd == CMD_WRITE && addr[AP_BIT] && burst_len_code == BL_1
		|=> precharge_strobe == 4'h0 [*2] ##1 precharge_strobe != 4'h0;
	endproperty
	a_ap: assert property (p_ap) else $error("auto close time");
	property p_hold;
		power_down && !cke |=> power_down && $stable(bank_open);
	endproperty
	a_hold: assert property (p_hold) else $error("woke early");
	property p_wake;
		s_wake |=> !power_down;
	endproperty
	a_wake: assert property (p_wake) else $error("no exit");
	property p_next;
		s_wake ##1 s_open |=> bank_open[$past(bk)];
	endproperty
	a_next: assert property (p_next) else $error("late command");
	property p_kind;
		power_down |-> active_power_down == (bank_open != 4'h0);
	endproperty
	a_kind: assert property (p_kind) else $error("wrong kind");
endmodule // sdram_wpp_sva
`default_nettype wire

// file: verification/sdram_ctrl_model.sv
// Behavioural memory controller on the command and data pins
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model
	import sdram_wr_pkg::*;
(
	input wire logic clk,
	output logic cke,
	output logic [3:0] cmd,
	output logic [ADDR_W-1:0] addr,
	output logic [1:0] bank,
	output logic [DQ_W-1:0] dq_in,
	output logic [MASK_W-1:0] dqm
);
	// Quiet pins at time zero
	initial
	begin
		cke = 1'b1;
		cmd = CMD_NOP;
		addr = 13'h0000;
		bank = 2'h0;
		dq_in = 16'h0000;
		dqm = 2'h0;
	end
	// One command cycle, driven just after the rising edge
	task automatic op(input logic [3:0] c, input logic [1:0] b,
		input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
		input logic [MASK_W-1:0] k, input logic e);
		@(posedge clk);
		#1;
		cke = e;
		cmd = c;
		bank = b;
		addr = a;
		dq_in = d;
		dqm = k;
	endtask
	// Released data lines flip so stale data never looks valid
	task automatic idle(input logic e);
		op(CMD_NOP, bank, addr, ~dq_in, 2'h0, e);
	endtask
	// Close after write recovery, masked, then wait the precharge period
	task automatic close(input logic [1:0] b, input logic all);
		repeat (WR_REC_INT) op(CMD_NOP, b, addr, ~dq_in, 2'h3, 1'b1);
		op(CMD_PRE, b, {2'h0, all, 10'h000}, ~dq_in, 2'h3, 1'b1);
		repeat (2) idle(1'b1);
	endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// file: verification/sdram_write_precharge_powerdown_tb.sv
// Self-checking bench for the DRAM write path block
`timescale 1ns/100ps
`default_nettype none
module sdram_write_precharge_powerdown_tb
	import sdram_wr_pkg::*;
;
	logic clk, rst_n, cke, arr_ready; // Clock, reset, controls
	logic [3:0] cmd; // Command strobes
	logic [ADDR_W-1:0] addr; // Address pins
	logic [1:0] bank; // Bank pins
	logic [2:0] burst_len_code; // Burst length
	logic [DQ_W-1:0] dq_in, dq_out, arr_data; // Data
	logic [MASK_W-1:0] dqm, arr_mask; // Masks
	logic dq_oe, write_path_ready, arr_valid, power_down, active_power_down;
	logic [1:0] arr_bank; // Head entry fields
	logic [ROW_W-1:0] arr_row;
	logic [COL_W-1:0] arr_col;
	logic [NBANK-1:0] bank_open, precharge_strobe; // Bank state
	logic [ROW_W-1:0] rows [NBANK]; // Open row per bank
	logic [41:0] q [$]; // Expected array entries
	int n_mismatch = 0;
	int total_checks = 0;
	int seed = 32'hb3f9;
	sdram_ctrl_model m (.clk(clk), .cke(cke), .cmd(cmd), .addr(addr),
		.bank(bank), .dq_in(dq_in), .dqm(dqm));
	sdram_write_precharge_powerdown dut (.clk(clk), .rst_n(rst_n),
		.cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
		.we_n(cmd[0]), .addr(addr), .bank_select_low(bank[0]),
		.bank_select_high(bank[1]), .burst_len_code(burst_len_code),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqm(dqm),
		.write_path_ready(write_path_ready), .arr_valid(arr_valid),
		.arr_ready(arr_ready), .arr_bank(arr_bank), .arr_row(arr_row),
		.arr_col(arr_col), .arr_data(arr_data), .arr_mask(arr_mask),
		.bank_open(bank_open), .precharge_strobe(precharge_strobe),
		.power_down(power_down), .active_power_down(active_power_down));
	// Verdict and end of run
	task automatic final_report;
		$display("mismatches %0d checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Compare one result
	task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Compare one status value
	task automatic cmp_state(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Write n elements of a burst of len from column c, noting each
	task automatic wr(input logic [1:0] b, input logic [COL_W-1:0] c,
		input logic [2:0] code, input int n, input int len, input logic ap);
		logic [DQ_W-1:0] d;
		logic [MASK_W-1:0] k;
		int s;
		for (int i = 0; i < n; i++)
		begin
			d = DQ_W'($random(seed));
			k = MASK_W'($random(seed));
			s = c + i;
			if (len == 512 && s > 511)
				s = s - 512 + c;
			else if (len < 512)
				s = (c & ~(len - 1)) | (s & (len - 1));
			m.op(i == 0 ? CMD_WRITE : CMD_NOP, b, {2'h0, ap, 1'b0, c}, d, k,
				1'b1);
			burst_len_code = code;
			q.push_back({b, rows[b], s[COL_W-1:0], d, k});
		end
	endtask
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Take the oldest note whenever the array takes an entry
	always @(posedge clk)
		if (rst_n && arr_valid === 1'b1 && arr_ready)
			cmp({arr_bank, arr_row, arr_col, arr_data, arr_mask},
				q.size() != 0 ? q.pop_front() : 42'h0);
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report;
	end
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		arr_ready = 1'b1;
		burst_len_code = BL_2;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int b = 0; b < NBANK; b++)
		begin
			rows[b] = ROW_W'($random(seed));
			m.op(CMD_ACT, 2'(b), rows[b], DQ_W'($random(seed)), 2'h0,
				1'b1);
		end
		wr(2'h0, 9'h004, BL_2, 2, 2, 1'b0);
		repeat (2) m.idle(1'b1);
		cmp_state(dq_out, 16'h0000);
		cmp_state(16'(dq_oe), 16'h0000);
		wr(2'h0, 9'h00a, BL_4, 2, 4, 1'b0);
		wr(2'h1, 9'h010, BL_1, 1, 1, 1'b0);
		wr(2'h2, 9'h021, BL_1, 1, 1, 1'b0);
		wr(2'h3, 9'h023, BL_8, 3, 8, 1'b0);
		m.op(CMD_READ, 2'h3, 13'h0000, DQ_W'($random(seed)), 2'h0,
			1'b1);
		wr(2'h1, 9'h1fe, BL_PAGE, 4, 512, 1'b0);
		m.op(CMD_BST, 2'h1, 13'h0000, DQ_W'($random(seed)), 2'h0,
			1'b1);
		repeat (3) m.idle(1'b1);
		arr_ready = 1'b0;
		wr(2'h2, 9'h000, BL_4, 4, 4, 1'b0);
		m.idle(1'b1);
		cmp_state(16'(write_path_ready), 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			m.idle(1'b1);
			arr_ready = 1'($random(seed));
		end
		arr_ready = 1'b1;
		m.close(2'h1, 1'b0);
		cmp_state(16'(bank_open), 16'h000d);
		wr(2'h0, 9'h005, BL_1, 1, 1, 1'b1);
		repeat (4) m.idle(1'b1);
		cmp_state(16'(bank_open), 16'h000c);
		m.idle(1'b0);
		m.op(CMD_WRITE, 2'h2, 13'h0000, DQ_W'($random(seed)),
			2'($random(seed)), 1'b0);
		cmp_state(16'({power_down, active_power_down}), 16'h0003);
		// Exit with an inhibit, other strobes and pins random
		m.op({1'b1, 3'($random(seed))}, 2'($random(seed)),
			ADDR_W'($random(seed)), DQ_W'($random(seed)),
			2'($random(seed)), 1'b1);
		m.op(CMD_ACT, 2'h1, rows[1], DQ_W'($random(seed)), 2'h0,
			1'b1);
		m.close(2'($random(seed)), 1'b1);
		repeat (2) m.idle(1'b0);
		cmp_state(16'({power_down, active_power_down}), 16'h0002);
		m.idle(1'b1);
		for (int i = 0; i < 50 && q.size() != 0; i++)
			m.idle(1'b1);
		cmp_state(16'(q.size()), 16'h0000);
		final_report;
	end
endmodule // sdram_write_precharge_powerdown_tb
bind sdram_write_precharge_powerdown sdram_wpp_sva chk (.clk(clk),
	.rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
	.we_n(we_n), .addr(addr), .bank_select_low(bank_select_low),
	.bank_select_high(bank_select_high), .burst_len_code(burst_len_code),
	.dq_oe(dq_oe), .write_path_ready(write_path_ready),
	.arr_valid(arr_valid), .bank_open(bank_open),
	.precharge_strobe(precharge_strobe), .power_down(power_down),
	.active_power_down(active_power_down));
`default_nettype wire
